// file: cbcc_top.sv
`timescale 1ns/1ps
module cbcc_top
  import cbcc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // harness code pins
  input wire logic [1:0] harness_code_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // message gating from the protocol engine
  input wire logic j1939_tx_req_in,
  input wire logic tool_tx_req_in,
  output logic j1939_tx_en_out,
  output logic tool_tx_en_out,
  // applied bus controller settings
  output logic [1:0] primary_bus_channel_rate_out,
  output logic [9:0] primary_bus_channel_presc_out,
  output logic [4:0] primary_bus_channel_seg1_out,
  output logic [4:0] primary_bus_channel_seg2_out,
  output logic [2:0] primary_bus_channel_sjw_out,
  output logic [1:0] secondary_bus_channel_rate_out,
  output logic [9:0] secondary_bus_channel_presc_out,
  output logic [1:0] unit_sel_out,
  output logic config_loaded_out
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // prescaler: clock cycles per quantum for a rate and quanta count
  function automatic logic [9:0] cbcc_presc(input logic [1:0] rate,
                                            input logic [4:0] tot);
    int kbps;
    int div;
    kbps = 1000;
    case (rate)
      CBCC_R125: kbps = 125;
      CBCC_R250: kbps = 250;
      CBCC_R500: kbps = 500;
      default: kbps = 1000;
    endcase
    div = CBCC_CLK_KHZ / (kbps * int'(tot));
    if (div < 1) begin
      div = 1;
    end
    return div[9:0];
  endfunction : cbcc_presc

  // clamp a value into a range
  function automatic logic [4:0] cbcc_clamp(input logic [4:0] v,
                                            input logic [4:0] lo,
                                            input logic [4:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : cbcc_clamp

  // ----------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------
  logic [1:0] hc_meta_q;
  logic [1:0] hc_sync_q;
  // harness pins come from outside; the first stage feeds only the second
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hc_meta_q <= 2'h0;
      hc_sync_q <= 2'h0;
    end else begin
      hc_meta_q <= harness_code_in;
      hc_sync_q <= hc_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CBCC_S_SETTLE, CBCC_S_LOAD, CBCC_S_RUN
  } cbcc_phase_t;

  typedef struct packed {
    cbcc_phase_t phase;
    logic [1:0] settle;
    // stored settings from software writes, timing fields clamped to their limits
    logic prot_j1939;
    logic hc_en;
    logic cust_en;
    logic [1:0] rate;
    logic [4:0] tot;
    logic [4:0] sp;
    logic [2:0] sjw;
    logic apply_req;
    // applied settings, frozen while running
    logic [1:0] act_rate;
    logic [4:0] act_tot;
    logic [4:0] act_sp;
    logic [2:0] act_sjw;
    logic act_prot;
    logic [1:0] unit;
    logic loaded;
    logic [31:0] rdata;
  } cbcc_state_t;

  cbcc_state_t s_q;
  cbcc_state_t s_d;

  cbcc_tq_if tq_if ();

  cbcc_seg u_seg (
    .tq(tq_if.calc)
  );

  // staged timing for the segment split: defaults unless custom is set
  assign tq_if.tot = s_q.act_tot;
  assign tq_if.sp = s_q.act_sp;
  assign tq_if.sjw = s_q.act_sjw;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic acc;
  logic wr;
  logic mapped;
  assign acc = psel_in && penable_in;
  assign wr = acc && pwrite_in;
  // zero wait states: every access completes in its first access cycle
  assign pready_out = 1'b1;
  always_comb begin
    case (paddr_in)
      CBCC_CTRL_OFS, CBCC_TQ_OFS, CBCC_STAT_OFS, CBCC_ACT_OFS,
      CBCC_APPLY_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr_out = acc && !mapped;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // register writes only change the stored copy
    if (wr) begin
      case (paddr_in)
        CBCC_CTRL_OFS: begin
          s_d.prot_j1939 = pwdata_in[CBCC_PROT_BIT];
          s_d.hc_en = pwdata_in[CBCC_HC_BIT];
          s_d.cust_en = pwdata_in[CBCC_CUST_BIT];
          s_d.rate = pwdata_in[CBCC_RATE_LSB +: 2];
        end
        CBCC_TQ_OFS: begin
          // out-of-range values saturate at the nearest limit
          s_d.tot = cbcc_clamp(pwdata_in[CBCC_TOT_LSB +: 5], CBCC_TOT_MIN,
                               CBCC_TOT_MAX);
          s_d.sp = cbcc_clamp(pwdata_in[CBCC_SP_LSB +: 5], CBCC_SP_MIN,
                              CBCC_SP_MAX);
          s_d.sjw = 3'(cbcc_clamp({2'h0, pwdata_in[CBCC_SJW_LSB +: 3]},
                                  {2'h0, CBCC_SJW_MIN},
                                  {2'h0, CBCC_SJW_MAX}));
        end
        // soft power cycle: keyed so a stray write cannot reload
        CBCC_APPLY_OFS: begin
          if (pwdata_in == CBCC_APPLY_KEY) begin
            s_d.apply_req = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // power-up sequence
    case (s_q.phase)
      CBCC_S_SETTLE: begin
        // let the harness synchroniser fill before sampling
        s_d.settle = s_q.settle + 2'h1;
        if (s_q.settle == 2'h3) begin
          s_d.phase = CBCC_S_LOAD;
        end
      end
      CBCC_S_LOAD: begin
        s_d.act_rate = s_q.rate;
        s_d.act_prot = s_q.prot_j1939;
        if (s_q.cust_en) begin
          s_d.act_tot = s_q.tot;
          s_d.act_sp = s_q.sp;
          s_d.act_sjw = s_q.sjw;
        end else begin
          s_d.act_tot = CBCC_TOT_DEF;
          s_d.act_sp = CBCC_SP_DEF;
          s_d.act_sjw = CBCC_SJW_DEF;
        end
        s_d.unit = s_q.hc_en ? hc_sync_q : 2'h0;
        s_d.loaded = 1'b1;
        s_d.apply_req = 1'b0;
        s_d.phase = CBCC_S_RUN;
      end
      CBCC_S_RUN: begin
        // applied values stay put until a power cycle
        if (s_q.apply_req) begin
          s_d.phase = CBCC_S_SETTLE;
          s_d.settle = 2'h0;
          s_d.loaded = 1'b0;
        end
      end
      default: s_d.phase = CBCC_S_SETTLE;
    endcase
    // read data registered at setup so it is valid in the access cycle
    s_d.rdata = 32'h0000_0000;
    if (psel_in && !penable_in && !pwrite_in) begin
      case (paddr_in)
        CBCC_CTRL_OFS: begin
          s_d.rdata[CBCC_PROT_BIT] = s_q.prot_j1939;
          s_d.rdata[CBCC_HC_BIT] = s_q.hc_en;
          s_d.rdata[CBCC_CUST_BIT] = s_q.cust_en;
          s_d.rdata[CBCC_RATE_LSB +: 2] = s_q.rate;
        end
        CBCC_TQ_OFS: begin
          s_d.rdata[CBCC_TOT_LSB +: 5] = s_q.tot;
          s_d.rdata[CBCC_SP_LSB +: 5] = s_q.sp;
          s_d.rdata[CBCC_SJW_LSB +: 3] = s_q.sjw;
        end
        CBCC_STAT_OFS: begin
          s_d.rdata[0] = s_q.loaded;
          s_d.rdata[1] = s_q.apply_req;
          s_d.rdata[3:2] = hc_sync_q;
        end
        CBCC_ACT_OFS: begin
          s_d.rdata[CBCC_TOT_LSB +: 5] = s_q.act_tot;
          s_d.rdata[CBCC_ACT_SP_LSB +: 5] = s_q.act_sp;
          s_d.rdata[CBCC_ACT_SJW_LSB +: 3] = tq_if.sjw_eff;
          s_d.rdata[CBCC_ACT_RATE_LSB +: 2] = s_q.act_rate;
          s_d.rdata[CBCC_ACT_UNIT_LSB +: 2] = s_q.unit;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
      s_q.phase <= CBCC_S_SETTLE;
      s_q.prot_j1939 <= 1'b1;
      s_q.hc_en <= 1'b1;
      s_q.cust_en <= 1'b0;
      s_q.rate <= CBCC_R250;
      s_q.tot <= CBCC_TOT_DEF;
      s_q.sp <= CBCC_SP_DEF;
      s_q.sjw <= CBCC_SJW_DEF;
      s_q.act_rate <= CBCC_R250;
      s_q.act_tot <= CBCC_TOT_DEF;
      s_q.act_sp <= CBCC_SP_DEF;
      s_q.act_sjw <= CBCC_SJW_DEF;
      s_q.act_prot <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata_out = s_q.rdata;
  // nothing leaves before the controller is loaded
  assign j1939_tx_en_out = j1939_tx_req_in && s_q.act_prot
                           && s_q.loaded;
  assign tool_tx_en_out = tool_tx_req_in && s_q.loaded;
  assign primary_bus_channel_rate_out = s_q.act_rate;
  assign primary_bus_channel_presc_out = cbcc_presc(s_q.act_rate,
                                                    s_q.act_tot);
  assign primary_bus_channel_seg1_out = tq_if.seg1;
  assign primary_bus_channel_seg2_out = tq_if.seg2;
  assign primary_bus_channel_sjw_out = tq_if.sjw_eff;
  // secondary has no setting at all
  assign secondary_bus_channel_rate_out = CBCC_R1000;
  assign secondary_bus_channel_presc_out = cbcc_presc(CBCC_R1000,
                                                      CBCC_TOT_DEF);
  assign unit_sel_out = s_q.unit;
  assign config_loaded_out = s_q.loaded;

endmodule : cbcc_top

// file: cbcc_pkg.sv
package cbcc_pkg;
  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CBCC_CTRL_OFS = 8'h00;
  localparam logic [7:0] CBCC_TQ_OFS = 8'h04;
  localparam logic [7:0] CBCC_STAT_OFS = 8'h08;
  localparam logic [7:0] CBCC_ACT_OFS = 8'h0C;
  localparam logic [7:0] CBCC_APPLY_OFS = 8'h10;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CBCC_PROT_BIT = 0;
  localparam int CBCC_HC_BIT = 1;
  localparam int CBCC_CUST_BIT = 2;
  localparam int CBCC_RATE_LSB = 4;
  localparam int CBCC_TOT_LSB = 0;
  localparam int CBCC_SP_LSB = 8;
  localparam int CBCC_SJW_LSB = 16;
  localparam int CBCC_ACT_SP_LSB = 8;
  localparam int CBCC_ACT_SJW_LSB = 16;
  localparam int CBCC_ACT_RATE_LSB = 20;
  localparam int CBCC_ACT_UNIT_LSB = 24;

  // ----------------------------------------------------------------------
  // encodings and limits
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CBCC_R125, CBCC_R250, CBCC_R500, CBCC_R1000
  } cbcc_rate_t;
  localparam logic [4:0] CBCC_TOT_MIN = 5'h08;
  localparam logic [4:0] CBCC_TOT_MAX = 5'h19;
  localparam logic [4:0] CBCC_TOT_DEF = 5'h0E;
  localparam logic [4:0] CBCC_SP_MIN = 5'h06;
  localparam logic [4:0] CBCC_SP_MAX = 5'h11;
  localparam logic [4:0] CBCC_SP_DEF = 5'h0C;
  localparam logic [2:0] CBCC_SJW_MIN = 3'h1;
  localparam logic [2:0] CBCC_SJW_MAX = 3'h4;
  localparam logic [2:0] CBCC_SJW_DEF = 3'h2;
  localparam logic [31:0] CBCC_APPLY_KEY = 32'h0000A55A;
  // clock 125 MHz; prescaler per rate so that tq*tot = bit time
  localparam int CBCC_CLK_KHZ = 125000;
endpackage : cbcc_pkg

// file: cbcc_if.sv
`timescale 1ns/1ps
interface cbcc_tq_if;
  logic [4:0] tot;
  logic [4:0] sp;
  logic [2:0] sjw;
  logic [4:0] seg1;
  logic [4:0] seg2;
  logic [2:0] sjw_eff;
  modport src (output tot, output sp, output sjw, input seg1, input seg2,
    input sjw_eff);
  modport calc (input tot, input sp, input sjw, output seg1, output seg2,
    output sjw_eff);
endinterface : cbcc_tq_if

// file: cbcc_seg.sv
`timescale 1ns/1ps
module cbcc_seg
  import cbcc_pkg::*;
(
  cbcc_tq_if.calc tq
);
  // ----------------------------------------------------------------------
  // segment split
  // ----------------------------------------------------------------------
  // sync is quantum 1; seg1 fills to the sample point, seg2 is the rest
  always_comb begin
    tq.seg1 = tq.sp - 5'h01;
    tq.seg2 = (tq.tot > tq.sp) ? tq.tot - tq.sp : 5'h01;
    // jump width clipped to seg2
    if ({2'h0, tq.sjw} > tq.seg2) begin
      tq.sjw_eff = tq.seg2[2:0];
    end else begin
      tq.sjw_eff = tq.sjw;
    end
  end
endmodule : cbcc_seg

// file: cbcc_monitor.sv
`timescale 1ns/1ps
module cbcc_monitor
  import cbcc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // apb request
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  // message gating
  input wire logic j1939_tx_req_in,
  input wire logic tool_tx_req_in,
  input wire logic j1939_tx_en_out,
  input wire logic tool_tx_en_out,
  // applied settings
  input wire logic [1:0] primary_bus_channel_rate_out,
  input wire logic [9:0] primary_bus_channel_presc_out,
  input wire logic [4:0] primary_bus_channel_seg1_out,
  input wire logic [4:0] primary_bus_channel_seg2_out,
  input wire logic [2:0] primary_bus_channel_sjw_out,
  input wire logic [1:0] secondary_bus_channel_rate_out,
  input wire logic [9:0] secondary_bus_channel_presc_out,
  input wire logic config_loaded_out
);
  // ----------------------------------------------------------------
  // short aliases
  // ----------------------------------------------------------------
  wire logic [4:0] s1_w = primary_bus_channel_seg1_out;
  wire logic [4:0] s2_w = primary_bus_channel_seg2_out;
  wire logic [2:0] sj_w = primary_bus_channel_sjw_out;
  wire logic [7:0] bit_w = 8'(s1_w) + 8'(s2_w) + 8'h01;
  wire logic apply_w = psel_in && penable_in && pwrite_in &&
    paddr_in == CBCC_APPLY_OFS && pwdata_in == CBCC_APPLY_KEY;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_j1939_gate: assert property (j1939_tx_en_out |->
    j1939_tx_req_in && config_loaded_out) else $error("j1939 gate");
  a_tool_pass: assert property (tool_tx_en_out ==
    (tool_tx_req_in && config_loaded_out)) else $error("tool gate");
  a_secondary_fixed: assert property (
    secondary_bus_channel_rate_out == 2'h3 &&
    secondary_bus_channel_presc_out == 10'h008) else $error("secondary");
  a_rate_frozen: assert property (
    config_loaded_out && $past(config_loaded_out) |->
    $stable(primary_bus_channel_rate_out)) else $error("rate moved");
  a_timing_frozen: assert property (
    config_loaded_out && $past(config_loaded_out) |->
    $stable({primary_bus_channel_presc_out, s1_w, s2_w, sj_w}))
    else $error("timing moved");
  a_sjw_within: assert property (sj_w >= 3'h1 &&
    {2'h0, sj_w} <= s2_w) else $error("jump width");
  a_quanta_range: assert property (bit_w >= 8'h08 &&
    bit_w <= 8'h19 && s1_w >= 5'h05 && s1_w <= 5'h10)
    else $error("quanta range");
  a_load_delay: assert property ($rose(rst_b_in) |->
    !config_loaded_out [*5] ##[1:2] config_loaded_out)
    else $error("load delay");
  a_apply_drop: assert property (apply_w |->
    ##[1:2] !config_loaded_out) else $error("apply ignored");

  // main scenarios reached
  c_loaded: cover property ($rose(config_loaded_out));
  c_apply: cover property (apply_w);
  c_tool_only: cover property (tool_tx_en_out && !j1939_tx_en_out);
endmodule : cbcc_monitor

bind cbcc_top cbcc_monitor u_mon (.sys_clk_in, .rst_b_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .j1939_tx_req_in,
  .tool_tx_req_in, .j1939_tx_en_out, .tool_tx_en_out,
  .primary_bus_channel_rate_out, .primary_bus_channel_presc_out,
  .primary_bus_channel_seg1_out, .primary_bus_channel_seg2_out,
  .primary_bus_channel_sjw_out, .secondary_bus_channel_rate_out,
  .secondary_bus_channel_presc_out, .config_loaded_out);

// file: cbcc_node_model.sv
`timescale 1ns/1ps
module cbcc_node_model
  import cbcc_pkg::*;
(
  // network rate and device rates
  input wire logic [1:0] node_rate_in,
  input wire logic [1:0] pri_rate_in,
  input wire logic [1:0] sec_rate_in,
  // link outcome
  output logic pri_ok_out,
  output logic tool_on_sec_out
);
  // peers only hear the device when rates agree
  assign pri_ok_out = pri_rate_in == node_rate_in;
  // tool falls back to the fixed-rate channel
  assign tool_on_sec_out = !pri_ok_out && sec_rate_in == 2'h3;
endmodule : cbcc_node_model

// file: can_bus_channel_config_tb.sv
`timescale 1ns/1ps
module can_bus_channel_config_tb
  import cbcc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] hcode = 2'h2;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pad = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic jreq = 1'b1;
  logic treq = 1'b1;
  logic [31:0] prd, rd;
  logic prdy, perr, er, jen, ten, lded, pok, tsec;
  logic [1:0] rate, srate, unit;
  logic [9:0] presc, spresc;
  logic [4:0] s1, s2;
  logic [2:0] sj;
  logic [4:0] exp_s1 = 5'h0B;
  int n_mismatch = 0;
  int n_compared = 0;
  int kb[4] = '{125, 250, 500, 1000};
  int ord[4] = '{0, 2, 3, 1};

  always #4 clk = ~clk;

  cbcc_top dut (.sys_clk_in(clk), .rst_b_in(rst_b), .harness_code_in(hcode),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pad),
    .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .j1939_tx_req_in(jreq), .tool_tx_req_in(treq),
    .j1939_tx_en_out(jen), .tool_tx_en_out(ten),
    .primary_bus_channel_rate_out(rate),
    .primary_bus_channel_presc_out(presc),
    .primary_bus_channel_seg1_out(s1), .primary_bus_channel_seg2_out(s2),
    .primary_bus_channel_sjw_out(sj),
    .secondary_bus_channel_rate_out(srate),
    .secondary_bus_channel_presc_out(spresc), .unit_sel_out(unit),
    .config_loaded_out(lded));
  // network stays at the default rate
  cbcc_node_model peer (.node_rate_in(2'h1), .pri_rate_in(rate),
    .sec_rate_in(srate), .pri_ok_out(pok), .tool_on_sec_out(tsec));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one idle edge first so psel is never assigned twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pad <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : apb

  task automatic wait_loaded;
    int n;
    n = 0;
    while (lded !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    if (n >= 30) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wait_loaded

  task automatic power_cycle;
    apb(1'b1, CBCC_APPLY_OFS, CBCC_APPLY_KEY);
    repeat (2) @(posedge clk);
    wait_loaded();
  endtask : power_cycle

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_protocol;
    apb(1'b1, CBCC_CTRL_OFS, 32'h12);
    repeat (2) @(posedge clk);
    chk(jen, 1'b1);
    power_cycle();
    chk(jen, 1'b0);
    chk(ten, 1'b1);
  endtask : t_protocol

  task automatic t_harness;
    apb(1'b1, CBCC_CTRL_OFS, 32'h11);
    power_cycle();
    chk(unit, 2'h0);
    hcode <= 2'h3;
    apb(1'b1, CBCC_CTRL_OFS, 32'h13);
    power_cycle();
    chk(unit, 2'h3);
  endtask : t_harness

  // rate is held until the soft power cycle, 250 restored last
  task automatic t_rate;
    logic [1:0] r, prev;
    prev = 2'h1;
    for (int i = 0; i < 4; i++) begin
      r = 2'(ord[i]);
      apb(1'b1, CBCC_CTRL_OFS, 32'h03 | (32'(r) << 4));
      repeat (2) @(posedge clk);
      chk(rate, prev);
      power_cycle();
      chk(rate, r);
      chk(presc, 32'(125000 / (kb[r] * 14)));
      chk(tsec, r != 2'h1);
      chk({srate, spresc}, {2'h3, 10'h008});
      prev = r;
    end
  endtask : t_rate

  task automatic tq_case(input logic c, input logic [31:0] tq,
    input logic [4:0] e1, input logic [4:0] e2, input logic [2:0] ej,
    input int tot);
    apb(1'b1, CBCC_CTRL_OFS, 32'h13 | (32'(c) << 2));
    apb(1'b1, CBCC_TQ_OFS, tq);
    repeat (2) @(posedge clk);
    chk(s1, exp_s1);
    power_cycle();
    chk({s1, s2}, {e1, e2});
    chk(sj, ej);
    chk(presc, 32'(125000 / (250 * tot)));
    exp_s1 = e1;
  endtask : tq_case

  initial begin
    repeat (3) @(posedge clk);
    chk({rate, presc, lded}, {2'h1, 10'h023, 1'b0});
    chk({s1, s2, sj}, {5'h0B, 5'h02, 3'h2});
    rst_b <= 1'b1;
    wait_loaded();
    chk(unit, 2'h2);
    chk({jen, ten}, 2'h3);
    apb(1'b0, CBCC_CTRL_OFS, 32'h0);
    chk(rd, 32'h13);
    apb(1'b0, CBCC_TQ_OFS, 32'h0);
    chk(rd, 32'h00020C0E);
    t_protocol();
    t_harness();
    t_rate();
    tq_case(1'b0, 32'h00041119, 5'h0B, 5'h02, 3'h2, 14);
    tq_case(1'b1, 32'h00041119, 5'h10, 5'h08, 3'h4, 25);
    tq_case(1'b1, 32'h00071F1F, 5'h10, 5'h08, 3'h4, 25);
    apb(1'b0, CBCC_TQ_OFS, 32'h0);
    chk(rd, 32'h00041119);
    tq_case(1'b1, 32'h00040608, 5'h05, 5'h02, 3'h2, 8);
    tq_case(1'b1, 32'h00000608, 5'h05, 5'h02, 3'h1, 8);
    apb(1'b0, CBCC_ACT_OFS, 32'h0);
    chk(rd, 32'h03110608);
    apb(1'b0, CBCC_STAT_OFS, 32'h0);
    chk(rd, 32'h0000000D);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd, er}, {32'h0, 1'b1});
    give_verdict();
  end
endmodule : can_bus_channel_config_tb
